// ---- pad_network.sv ----
// Behavioural model of the circuitry outside the port 1 pins
`timescale 1ns/1ps
module pad_network (
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext_level,
   output logic      [7:0] pin_in
);
   // Released pins follow the outside level, so no old value lingers
   assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : pad_network

// ---- pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
   input  wire logic mclk,
   input  wire logic rst,
   pin_sync_if.sync  bus
);
   import port1_pkg::*;
   logic [PORT_W-1:0] s1;
   logic [PORT_W-1:0] s2;
   logic [PORT_W-1:0] s3;
   logic [PORT_W-1:0] level;

   // Stage one feeds stage two only, to keep metastability contained
   always_ff @(posedge mclk) begin
      if (rst) begin
         s1 <= RST_PIN_SYNC;
         s2 <= RST_PIN_SYNC;
         s3 <= RST_PIN_SYNC;
      end else begin
         s1 <= bus.raw;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A bit changes only once stages two and three agree
   always_ff @(posedge mclk) begin
      if (rst) begin
         level <= RST_PIN_SYNC;
      end else begin
         level <= (s2 & ~(s2 ^ s3)) | (level & (s2 ^ s3));
      end
   end

   assign bus.level = level;
endmodule : pin_sync

// ---- pin_sync_if.sv ----
// Carrier between the top module and the pin input synchroniser
`timescale 1ns/1ps
interface pin_sync_if;
   import port1_pkg::*;
   logic [PORT_W-1:0] raw;
   logic [PORT_W-1:0] level;
   modport sync (input raw, output level);
   modport user (output raw, input level);
endinterface : pin_sync_if

// ---- port1_data_latch.sv ----
// Port 1 data latch, drive selection and pin read-back with Wishbone slave
`timescale 1ns/1ps
module port1_data_latch (
   input  wire logic                        mclk,
   input  wire logic                        rst,
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [port1_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [port1_pkg::DAT_W-1:0] wb_dat_i,
   output logic      [port1_pkg::DAT_W-1:0] wb_dat_o,
   output logic                             wb_ack_o,
   input  wire logic [port1_pkg::PORT_W-1:0] pin_in,
   output logic      [port1_pkg::PORT_W-1:0] pin_out,
   output logic      [port1_pkg::PORT_W-1:0] pin_oe,
   input  wire logic [port1_pkg::PORT_W-1:0] xbar_claim,
   input  wire logic [port1_pkg::PORT_W-1:0] periph_out,
   input  wire logic [port1_pkg::PORT_W-1:0] periph_oe,
   input  wire logic                        emif_nonmux,
   input  wire logic                        emif_drive,
   input  wire logic [port1_pkg::PORT_W-1:0] emif_addr_hi,
   output logic      [port1_pkg::PORT_W-1:0] aux_analog_channel_en,
   output logic      [port1_pkg::PORT_W-1:0] xbar_skip,
   output logic      [port1_pkg::PORT_W-1:0] crossbar_config_a,
   output logic      [port1_pkg::PORT_W-1:0] crossbar_config_b,
   output logic      [port1_pkg::PORT_W-1:0] crossbar_config_c
);
   import port1_pkg::*;

   logic [PORT_W-1:0] port1_pin_latch;
   logic [PORT_W-1:0] port1_drive_select;
   logic [PORT_W-1:0] port1_analog_digital_select;

   pin_sync_if sif ();

   assign sif.raw = pin_in;

   pin_sync u_sync (
      .mclk (mclk),
      .rst  (rst),
      .bus  (sif)
   );

   // Bus decode; a request is served once, in the cycle before ack
   // Masking with ack stops a held strobe being taken on every edge
   wire               req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire               wr        = req & wb_we_i & wb_sel_i[0];
   wire               hit_latch = wb_adr_i == OFS_PIN_LATCH;
   wire               hit_drive = wb_adr_i == OFS_DRIVE_SEL;
   wire               hit_anal  = wb_adr_i == OFS_ANALOG_SEL;
   wire               hit_xa    = wb_adr_i == OFS_XBAR_A;
   wire               hit_xb    = wb_adr_i == OFS_XBAR_B;
   wire               hit_xc    = wb_adr_i == OFS_XBAR_C;

   // Digital pins only; analog pins have their input path off
   wire [PORT_W-1:0]  digital   = port1_analog_digital_select;
   // Reading pads, not the latch, shows a pin that the board holds
   // pin read-back
   wire [PORT_W-1:0]  pin_read  = sif.level & digital;

   // Readback selection; unmapped addresses read as zero
   wire [PORT_W-1:0]  rd_byte   =
      hit_latch ? pin_read :
      hit_drive ? port1_drive_select :
      hit_anal  ? port1_analog_digital_select :
      hit_xa    ? crossbar_config_a :
      hit_xb    ? crossbar_config_b :
      hit_xc    ? crossbar_config_c : 8'h00;

   // Bus answer: ack registered, so one wait state; ack drops after one cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         port1_pin_latch <= RST_PIN_LATCH;
      end else if (wr && hit_latch) begin
         port1_pin_latch <= wb_dat_i[PORT_W-1:0];
      end
   end

   // Mode and crossbar configuration registers
   // A write with byte lane zero off changes nothing
   always_ff @(posedge mclk) begin
      if (rst) begin
         port1_drive_select          <= RST_DRIVE_SEL;
         port1_analog_digital_select <= RST_ANALOG_SEL;
         crossbar_config_a           <= RST_XBAR;
         crossbar_config_b           <= RST_XBAR;
         crossbar_config_c           <= RST_XBAR;
      end else if (wr) begin
         if (hit_drive) port1_drive_select <= wb_dat_i[PORT_W-1:0];
         if (hit_anal) port1_analog_digital_select <= wb_dat_i[PORT_W-1:0];
         if (hit_xa) crossbar_config_a <= wb_dat_i[PORT_W-1:0];
         if (hit_xb) crossbar_config_b <= wb_dat_i[PORT_W-1:0];
         if (hit_xc) crossbar_config_c <= wb_dat_i[PORT_W-1:0];
      end
   end

   wire               emif_act  = emif_nonmux & emif_drive;
   // analog pins never granted to the crossbar
   wire [PORT_W-1:0]  claim_eff = xbar_claim & digital;
   wire [PORT_W-1:0]  own       = ~claim_eff & ~{PORT_W{emif_act}};
   // An open-drain high is released; the board decides the level
   // latch low drives low, high drives only in push-pull
   // analog pins keep latch and mode driven output
   wire [PORT_W-1:0]  latch_oe  = ~port1_pin_latch | port1_drive_select;
   wire [PORT_W-1:0]  next_out  =
      emif_act ? emif_addr_hi :
      (claim_eff & periph_out) | (~claim_eff & port1_pin_latch);
   wire [PORT_W-1:0]  next_oe   =
      emif_act ? {PORT_W{1'b1}} :
      (claim_eff & periph_oe) | (~claim_eff & latch_oe);

   // Pad drive is registered so the pins never see decode glitches
   // Reset leaves every pad released, so nothing fights the board
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_out               <= RST_PIN_LATCH;
         pin_oe                <= 8'h00;
         aux_analog_channel_en <= 8'h00;
         xbar_skip             <= 8'h00;
      end else begin
         pin_out               <= next_out;
         pin_oe                <= next_oe;
         // analog channel n is pin n
         aux_analog_channel_en <= ~port1_analog_digital_select;
         xbar_skip             <= ~port1_analog_digital_select;
      end
   end

   // Checks on the logic above
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence latch_write_s;
      wr && hit_latch;
   endsequence

   sequence latch_read_s;
      req && !wb_we_i && hit_latch;
   endsequence

   // One taken request gives exactly one ack, then a quiet cycle
   sequence ack_pulse_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   property latch_store_p;
      latch_write_s |=> port1_pin_latch == $past(wb_dat_i[PORT_W-1:0])
         ##1 !wb_ack_o;
   endproperty

   property pin_read_p;
      latch_read_s |=> wb_ack_o && wb_dat_o[PORT_W-1:0] == $past(pin_read)
         && wb_dat_o[DAT_W-1:PORT_W] == 24'h00_0000;
   endproperty

   // Pad outputs are registered, so each check compares against the
   // decode one edge back; the edge that ends a reset still shows the
   // reset values, hence the !rst antecedent
   latch_low_a: assert property (
      !rst |=> ((pin_out & pin_oe & $past(own))
                == ($past(port1_pin_latch) & pin_oe & $past(own))) &&
      (($past(own) & ~$past(port1_pin_latch) & (pin_out | ~pin_oe))
       == 8'h00))
      else $error("Own pin with latch 0 not driven low");
   drive_mode_a: assert property (
      !rst |=> ((pin_oe ^ $past(latch_oe)) & $past(own)) == 8'h00)
      else $error("Own pin enable disagrees with latch and mode");
   xbar_claim_a: assert property (
      !rst |=> ((pin_out ^ $past(periph_out)) & $past(claim_eff)
                & ~{PORT_W{$past(emif_act)}}) == 8'h00)
      else $error("Claimed pin driven from the latch");
   xbar_enable_a: assert property (
      !rst |=> ((pin_oe ^ $past(periph_oe)) & $past(claim_eff)
                & ~{PORT_W{$past(emif_act)}}) == 8'h00)
      else $error("Claimed pin enable not from the peripheral");
   // Writes to OFS_XBAR_A land in crossbar_config_a unchanged
   xbar_cfg_a: assert property (
      wr && hit_xa |=> crossbar_config_a == $past(wb_dat_i[PORT_W-1:0]))
      else $error("Crossbar configuration write not stored");
   latch_write_a: assert property (latch_store_p)
      else $error("Latch write not stored");
   // A write with the low byte lane off must leave the latch alone
   lane_off_a: assert property (
      req && wb_we_i && !wb_sel_i[0] |=> $stable(port1_pin_latch))
      else $error("Latch written with byte lane zero off");
   pin_read_a: assert property (pin_read_p)
      else $error("Port read does not return pin level");
   bus_ack_a: assert property (
      req |=> ack_pulse_s)
      else $error("Bus request not answered by one ack pulse");
   analog_chan_a: assert property (
      !rst |=> aux_analog_channel_en == ~$past(port1_analog_digital_select))
      else $error("Analog channel enable wrong");
   analog_skip_a: assert property (
      !rst |=> xbar_skip == ~$past(port1_analog_digital_select) &&
      ($past(pin_read) & ~$past(digital)) == 8'h00)
      else $error("Analog pin not skipped or input not disabled");
   analog_drive_a: assert property (
      !rst && !emif_act |=> ((pin_oe ^ $past(latch_oe)) & ~$past(digital))
      == 8'h00)
      else $error("Analog pin drive not from latch and mode");
   emif_drive_a: assert property (
      !rst && emif_act |=> pin_oe == 8'hff && pin_out == $past(emif_addr_hi))
      else $error("Memory interface address not on pins");
   reset_latch_a: assert property (
      @(posedge mclk) disable iff (1'b0)
      rst |=> port1_pin_latch == RST_PIN_LATCH && pin_oe == 8'h00)
      else $error("Latch not all ones after reset");
endmodule : port1_data_latch

// ---- port1_data_latch_tb.sv ----
// Self-checking bench for the port 1 data latch block
`timescale 1ns/1ps
module port1_data_latch_tb;
   import port1_pkg::*;
   typedef struct packed {logic [7:0] lat, drv, clm, po, pe, eo, ee;} row_t;
   logic        mclk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
   logic        nonmux = 0, edrv = 0, ack;
   logic [7:0]  adr = 0, claim = 0, pout = 0, poe = 0, ahi = 0;
   logic [7:0]  ext = 8'h96, p_in, p_out, p_oe, aux, skip, ca, cb, cc;
   logic [3:0]  sel = 4'hf, lane = 4'hf;
   logic [31:0] wdat = 0, rd, dat_o;
   int          n_mismatch = 0;
   int          n_checks = 0;
   // Plain drive, push-pull, all low, half claimed by a peripheral
   row_t rows [4] = '{'{8'ha5, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha5, 8'h5a},
                      '{8'ha5, 8'hf0, 8'h00, 8'h00, 8'h00, 8'ha5, 8'hfa},
                      '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff},
                      '{8'h3c, 8'h0f, 8'hf0, 8'haa, 8'h60, 8'hac, 8'h6f}};

   always #25 mclk = ~mclk;

   port1_data_latch uut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pin_in(p_in),
      .pin_out(p_out), .pin_oe(p_oe), .xbar_claim(claim),
      .periph_out(pout), .periph_oe(poe), .emif_nonmux(nonmux),
      .emif_drive(edrv), .emif_addr_hi(ahi), .aux_analog_channel_en(aux),
      .xbar_skip(skip), .crossbar_config_a(ca), .crossbar_config_b(cb),
      .crossbar_config_c(cc));

   pad_network ext_side (.pin_out(p_out), .pin_oe(p_oe), .ext_level(ext),
      .pin_in(p_in));

   // One classic cycle; held until ack is sampled high
   task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      cyc <= 1;
      stb <= 1;
      sel <= lane;
      we <= w;
      adr <= a;
      wdat <= {24'h00_0000, d};
      do @(posedge mclk); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 0;
      stb <= 0;
      we <= 0;
   endtask : wb

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task final_report();
      if (n_mismatch == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   // Watchdog far beyond the 125 or so cycles the tests need
   initial begin
      #150000;
      n_mismatch++;
      final_report();
   end

   initial begin
      repeat (5) @(posedge mclk);
      rst <= 0;
      repeat (5) @(posedge mclk);
      chk("pin_out", 8'hff, p_out);
      chk("pin_oe", 8'h00, p_oe);
      chk("aux", 8'h00, aux);
      wb(1, OFS_XBAR_A, 8'h11);
      wb(1, OFS_XBAR_B, 8'h22);
      wb(1, OFS_XBAR_C, 8'h33);
      chk("cfg", 24'h11_2233, {ca, cb, cc});
      wb(0, 8'h20, 8'h00);
      chk("unmapped", 32'h0000_0000, rd);
      // Byte lane zero off: write ignored, register reads back unchanged
      lane = 4'he;
      wb(1, OFS_DRIVE_SEL, 8'hff);
      lane = 4'hf;
      wb(0, OFS_DRIVE_SEL, 8'h00);
      chk("drive_sel", 32'h0000_0000, rd);
      wb(0, OFS_ANALOG_SEL, 8'h00);
      chk("analog_sel", 32'h0000_00ff, rd);
      foreach (rows[i]) begin
         wb(1, OFS_PIN_LATCH, rows[i].lat);
         wb(1, OFS_DRIVE_SEL, rows[i].drv);
         claim <= rows[i].clm;
         pout <= rows[i].po;
         poe <= rows[i].pe;
         repeat (6) @(posedge mclk);
         chk("pin_out", rows[i].eo, p_out);
         chk("pin_oe", rows[i].ee, p_oe);
         wb(0, OFS_PIN_LATCH, 8'h00);
         chk("read", (rows[i].eo & rows[i].ee) | (ext & ~rows[i].ee), rd);
      end
      // Low nibble analog: claims there ignored, latch still drives
      wb(1, OFS_ANALOG_SEL, 8'hf0);
      wb(1, OFS_PIN_LATCH, 8'h50);
      wb(1, OFS_DRIVE_SEL, 8'h00);
      claim <= 8'h0f;
      pout <= 8'h0f;
      poe <= 8'h05;
      repeat (6) @(posedge mclk);
      chk("aux", 8'h0f, aux);
      chk("skip", 8'h0f, skip);
      chk("pin_out", 8'h50, p_out);
      chk("pin_oe", 8'haf, p_oe);
      wb(0, OFS_PIN_LATCH, 8'h00);
      chk("read", 32'h0000_0010, rd);
      // Memory interface override, then back to the latch
      nonmux <= 1;
      edrv <= 1;
      ahi <= 8'hc3;
      repeat (2) @(posedge mclk);
      chk("pin_out", 8'hc3, p_out);
      chk("pin_oe", 8'hff, p_oe);
      edrv <= 0;
      repeat (2) @(posedge mclk);
      chk("pin_out", 8'h50, p_out);
      nonmux <= 0;
      edrv <= 1;
      repeat (2) @(posedge mclk);
      chk("pin_oe", 8'haf, p_oe);
      // Reset in mid-run: latch back to ones, every pad released
      edrv <= 0;
      claim <= 8'h00;
      rst <= 1;
      repeat (5) @(posedge mclk);
      rst <= 0;
      repeat (2) @(posedge mclk);
      chk("pin_out", 8'hff, p_out);
      chk("pin_oe", 8'h00, p_oe);
      chk("cfg", 32'h0000_0000, {ca, cb, cc});
      wb(0, OFS_ANALOG_SEL, 8'h00);
      chk("analog_sel", 32'h0000_00ff, rd);
      final_report();
   end
endmodule : port1_data_latch_tb

// ---- port1_pkg.sv ----
// Constants and register map for the port 1 data latch block
// Summary of operation
// - Latch 0 drives low; 1 per drive mode
// - Crossbar-claimed pins ignore the latch value
// - Port read returns sensed pin levels
// - Every pin selectable as aux analog channel
// - Analog pins skipped by crossbar, input disabled
// - Analog pins still driven from latch, mode
// - Memory interface drives address high byte
package port1_pkg;
   localparam int PORT_W = 8;
   localparam int ADR_W  = 8;
   localparam int DAT_W  = 32;

   // Register byte offsets
   localparam logic [ADR_W-1:0] OFS_PIN_LATCH   = 8'h00;
   localparam logic [ADR_W-1:0] OFS_DRIVE_SEL   = 8'h04;
   localparam logic [ADR_W-1:0] OFS_ANALOG_SEL  = 8'h08;
   localparam logic [ADR_W-1:0] OFS_XBAR_A      = 8'h0c;
   localparam logic [ADR_W-1:0] OFS_XBAR_B      = 8'h10;
   localparam logic [ADR_W-1:0] OFS_XBAR_C      = 8'h14;

   // Reset values
   localparam logic [PORT_W-1:0] RST_PIN_LATCH  = 8'hff;
   localparam logic [PORT_W-1:0] RST_DRIVE_SEL  = 8'h00;
   localparam logic [PORT_W-1:0] RST_ANALOG_SEL = 8'hff;
   localparam logic [PORT_W-1:0] RST_XBAR       = 8'h00;
   localparam logic [PORT_W-1:0] RST_PIN_SYNC   = 8'hff;
endpackage : port1_pkg
